// File: rtl/ubc_pkg.sv
// How it works
// R1: Oscillator clock divided by sixteen first
// R2: Divisor ranges one to 65535
// R3: Software picks divisor from clock and rate
// R4: Divisor split into high and low bytes
// R5: Shift register fed by sixteen-byte FIFO
// R6: Each bit lasts sixteen sampling ticks
// R7: Start, data, optional parity, stop bits
// R8: Data sent least significant bit first
// R9: FIFO mode writes advance write pointer
// R10: Non-FIFO: empty flag on shift load
// R11: Transmit interrupt only when enabled
// R12: Fully-empty needs shift register and FIFO empty
// R13: FIFO mode: empty flag follows FIFO empty
// R14: Host writes at most sixteen bytes ahead
// R15: Start validated mid-bit after eight ticks
// R16: Later bits sampled at centre, sixteen apart
// R17: Parity, framing, break in status bits 2-4
// R18: Receive FIFO sixteen entries of eleven bits
// R19: Data read pops and updates error flags
// R20: Receive interrupt per char or trigger, enabled
// R21: Timeout after four chars plus twelve bits; code counts four data-bit word lengths plus twelve bits
// R22: Holding register shows oldest unread char
// R23: Divisor bytes at 0/1 when bit 7 set
// R24: Timeout restarts on receive or read
package ubc_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_IER = 3'h1;
	localparam logic [2:0] ADDR_ISR_FCR = 3'h2;
	localparam logic [2:0] ADDR_LCR = 3'h3;
	localparam logic [2:0] ADDR_LSR = 3'h5;
	localparam logic [2:0] ADDR_SPR = 3'h7;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int LCR_DLAB = 7;
	localparam int LCR_BRK = 6;
	localparam int LCR_STICK = 5;
	localparam int LCR_EVEN = 4;
	localparam int LCR_PEN = 3;
	localparam int LCR_STOP = 2;
	localparam int FCR_EN = 0;
	localparam int FCR_RXRST = 1;
	localparam int FCR_TXRST = 2;
	localparam int IER_RX = 0;
	localparam int IER_TX = 1;
	localparam int IER_LS = 2;
	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [7:0] LCR_RST = 8'h00;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam logic [3:0] PRESCALE = 4'hF;
	localparam logic [3:0] HALF_BIT = 4'h7;
	localparam logic [3:0] FULL_BIT = 4'hF;
	localparam int FIFO_DEPTH = 16;
	localparam int TO_EXTRA_BITS = 12;
	// ----------------------------------------
	// Interrupt identification codes
	// ----------------------------------------
	localparam logic [3:0] ID_NONE = 4'h1;
	localparam logic [3:0] ID_LINE = 4'h6;
	localparam logic [3:0] ID_RXD = 4'h4;
	localparam logic [3:0] ID_TMO = 4'hC;
	localparam logic [3:0] ID_TXE = 4'h2;

	// Host access bundle
	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} ubc_acc_t;

	// Received character with error tags
	typedef struct packed {
		logic brk;
		logic frm;
		logic par;
		logic [7:0] data;
	} ubc_rxch_t;
endpackage

// File: rtl/ubc_fifo.sv
module ubc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Control
	input wire logic i_clr,
	input wire logic i_push,
	input wire logic [WIDTH-1:0] i_data,
	input wire logic i_pop,
	// Status
	output logic [WIDTH-1:0] o_data,
	output logic o_empty,
	output logic o_full,
	output logic [$clog2(DEPTH):0] o_count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0] cnt_ff;
	logic do_push;
	logic do_pop;

	assign do_push = i_push && (cnt_ff != (AW+1)'(DEPTH) || i_pop);
	assign do_pop = i_pop && cnt_ff != '0;
	assign o_data = mem_ff[rp_ff];
	assign o_empty = cnt_ff == '0;
	assign o_full = cnt_ff == (AW+1)'(DEPTH);
	assign o_count = cnt_ff;

	always_ff @(posedge i_clk) begin
		if (do_push)
			mem_ff[wp_ff] <= i_data;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else if (i_clr) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (do_push)
				wp_ff <= wp_ff + 1'b1;
			if (do_pop)
				rp_ff <= rp_ff + 1'b1;
			cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule

// File: rtl/ubc_baud.sv
module ubc_baud (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Divisor
	input wire logic [15:0] i_div,
	// 16x sampling tick
	output logic o_tick
);
	import ubc_pkg::*;
	logic [3:0] pre_ff;
	logic [15:0] cnt_ff;
	logic tick_ff;

	assign o_tick = tick_ff;

	// ----------------------------------------
	// Fixed prescale, then divisor
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pre_ff <= '0;
			cnt_ff <= 16'h0001;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= 1'b0;
			pre_ff <= pre_ff + 1'b1;                 // [R1]
			if (pre_ff == PRESCALE) begin
				// Zero divisor treated as one
				if (cnt_ff >= i_div || cnt_ff == 16'hFFFF) begin // [R2]
					cnt_ff <= 16'h0001;
					tick_ff <= 1'b1;
				end else
					cnt_ff <= cnt_ff + 16'h0001;
			end
		end
	end
endmodule

// File: rtl/ubc_core.sv
module ubc_core (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Host access, one-cycle strobes
	input wire ubc_pkg::ubc_acc_t i_acc,
	output logic [7:0] o_rdata,
	// Serial line
	input wire logic i_rx,
	output logic o_tx,
	// Interrupt request
	output logic o_int
);
	import ubc_pkg::*;

	logic [7:0] lcr_ff, ier_ff, fcr_ff, spr_ff, dll_ff, dlm_ff;
	logic [7:0] rdata_ff;
	logic tick;
	logic rx_s1_ff, rx_s2_ff, rx_prev_ff;
	logic fifo_mode;
	logic thr_wr, rhr_rd, lsr_rd;
	logic [7:0] nxt_rdata;

	assign fifo_mode = fcr_ff[FCR_EN];
	assign thr_wr = i_acc.wr && i_acc.addr == ADDR_DATA && !lcr_ff[LCR_DLAB];
	assign rhr_rd = i_acc.rd && i_acc.addr == ADDR_DATA && !lcr_ff[LCR_DLAB];
	assign lsr_rd = i_acc.rd && i_acc.addr == ADDR_LSR;

	function automatic logic [3:0] data_bits(input logic [1:0] wl);
		return 4'h5 + {2'b00, wl};
	endfunction

	ubc_baud u_baud (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_div({dlm_ff, dll_ff}),                 // [R4]
		.o_tick(tick)
	);

	// ----------------------------------------
	// Host register writes
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lcr_ff <= LCR_RST;
			ier_ff <= 8'h00;
			fcr_ff <= 8'h00;
			spr_ff <= 8'h00;
			dll_ff <= DIV_RST[7:0];
			dlm_ff <= DIV_RST[15:8];
		end else begin
			fcr_ff[FCR_RXRST] <= 1'b0;
			fcr_ff[FCR_TXRST] <= 1'b0;
			if (i_acc.wr) begin
				case (i_acc.addr)
				ADDR_DATA: if (lcr_ff[LCR_DLAB])
					dll_ff <= i_acc.wdata;               // [R23]
				ADDR_IER: if (lcr_ff[LCR_DLAB])
					dlm_ff <= i_acc.wdata;               // [R23]
				else
					ier_ff <= {4'h0, i_acc.wdata[3:0]};
				ADDR_ISR_FCR: fcr_ff <= i_acc.wdata;
				ADDR_LCR: lcr_ff <= i_acc.wdata;
				ADDR_SPR: spr_ff <= i_acc.wdata;
				default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_PAR = 3'b011,
		TX_STOP = 3'b100
	} ubc_tx_st_t;
	ubc_tx_st_t tx_st_ff;
	logic [7:0] tsr_ff;
	logic [3:0] tx_tk_ff, tx_bit_ff;
	logic tx_par_ff, tx_ff, thr_empty_ff;
	logic [7:0] txf_q;
	logic txf_empty, txf_full, tx_load;
	logic [3:0] nbits;

	assign nbits = data_bits(lcr_ff[1:0]);
	// Non-FIFO mode is the same FIFO clamped to one entry
	assign tx_load = tx_st_ff == TX_IDLE && !txf_empty;

	ubc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (        // [R5]
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_clr(fcr_ff[FCR_TXRST]),
		.i_push(thr_wr && (fifo_mode || txf_empty)),       // [R9] [R14]
		.i_data(i_acc.wdata),
		.i_pop(tx_load),
		.o_data(txf_q),
		.o_empty(txf_empty),
		.o_full(txf_full),
		.o_count()
	);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_st_ff <= TX_IDLE;
			tsr_ff <= 8'h00;
			tx_tk_ff <= 4'h0;
			tx_bit_ff <= 4'h0;
			tx_par_ff <= 1'b0;
			tx_ff <= 1'b1;
		end else begin
			case (tx_st_ff)
			TX_IDLE: begin
				tx_ff <= 1'b1;
				if (tx_load) begin
					tsr_ff <= txf_q;
					tx_par_ff <= ~lcr_ff[LCR_EVEN];
					tx_tk_ff <= 4'h0;
					tx_st_ff <= TX_START;                    // [R7]
				end
			end
			default: if (tick) begin
				tx_tk_ff <= tx_tk_ff + 1'b1;
				if (tx_tk_ff == FULL_BIT) begin          // [R6]
					case (tx_st_ff)
					TX_START: begin
						tx_st_ff <= TX_DATA;
						tx_bit_ff <= 4'h0;
					end
					TX_DATA: begin
						tsr_ff <= {1'b0, tsr_ff[7:1]};       // [R8]
						tx_par_ff <= tx_par_ff ^ tsr_ff[0];
						tx_bit_ff <= tx_bit_ff + 1'b1;
						if (tx_bit_ff + 1'b1 == nbits) begin
							tx_st_ff <= lcr_ff[LCR_PEN] ? TX_PAR : TX_STOP;
							tx_bit_ff <= 4'h0;
						end
					end
					TX_PAR: begin
						tx_st_ff <= TX_STOP;
						tx_bit_ff <= 4'h0;
					end
					default: begin
						tx_bit_ff <= tx_bit_ff + 1'b1;
						if (!lcr_ff[LCR_STOP] || tx_bit_ff == 4'h1)
							tx_st_ff <= TX_IDLE;
					end
					endcase
				end
				case (tx_st_ff)
				TX_START: tx_ff <= 1'b0;
				TX_DATA: tx_ff <= tsr_ff[0];
				TX_PAR: tx_ff <= lcr_ff[LCR_STICK] ?
					~lcr_ff[LCR_EVEN] : tx_par_ff;
				default: tx_ff <= 1'b1;
				endcase
			end
			endcase
		end
	end

	// Empty flag set on move to shift register or FIFO drain
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			thr_empty_ff <= 1'b1;
		else
			// Registered so a one-entry hold still shows a busy cycle
			thr_empty_ff <= txf_empty;                   // [R10] [R13]
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_BITS = 2'b10
	} ubc_rx_st_t;
	ubc_rx_st_t rx_st_ff;
	logic [7:0] rsr_ff;
	logic [3:0] rx_tk_ff, rx_bit_ff, rx_total;
	logic rx_par_ff, rx_push_ff, rx_ovr_ff, rx_zero_ff;
	ubc_rxch_t rx_ch_ff, rxf_q;
	logic rxf_empty, rxf_full;
	logic [4:0] rxf_cnt;

	assign rx_total = nbits + {3'b000, lcr_ff[LCR_PEN]};

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
		end else begin
			rx_s1_ff <= i_rx;
			rx_s2_ff <= rx_s1_ff;
			rx_prev_ff <= rx_s2_ff;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_st_ff <= RX_IDLE;
			rsr_ff <= 8'h00;
			rx_tk_ff <= 4'h0;
			rx_bit_ff <= 4'h0;
			rx_par_ff <= 1'b0;
			rx_zero_ff <= 1'b0;
			rx_push_ff <= 1'b0;
			rx_ch_ff <= '0;
		end else begin
			rx_push_ff <= 1'b0;
			case (rx_st_ff)
			RX_IDLE: if (rx_prev_ff && !rx_s2_ff) begin
				rx_tk_ff <= 4'h0;
				rx_st_ff <= RX_START;
			end
			RX_START: if (tick) begin
				rx_tk_ff <= rx_tk_ff + 1'b1;
				if (rx_tk_ff == HALF_BIT) begin          // [R15]
					rx_tk_ff <= 4'h0;
					rx_bit_ff <= 4'h0;
					rx_par_ff <= ~lcr_ff[LCR_EVEN];
					rx_zero_ff <= 1'b1;
					rsr_ff <= 8'h00;
					rx_st_ff <= rx_s2_ff ? RX_IDLE : RX_BITS;
				end
			end
			RX_BITS: if (tick) begin
				rx_tk_ff <= rx_tk_ff + 1'b1;
				if (rx_tk_ff == FULL_BIT) begin          // [R16]
					rx_bit_ff <= rx_bit_ff + 1'b1;
					rx_zero_ff <= rx_zero_ff & ~rx_s2_ff;
					rx_par_ff <= rx_par_ff ^ rx_s2_ff;
					if (rx_bit_ff < nbits)
						rsr_ff[rx_bit_ff[2:0]] <= rx_s2_ff;  // [R8]
					if (rx_bit_ff == rx_total) begin
						rx_ch_ff.data <= rsr_ff;
						rx_ch_ff.frm <= ~rx_s2_ff;           // [R17]
						rx_ch_ff.brk <= rx_zero_ff & ~rx_s2_ff;
						rx_ch_ff.par <= lcr_ff[LCR_PEN] & (lcr_ff[LCR_STICK] ?
							rx_par_ff ^ (^rsr_ff) :
							rx_par_ff);
						rx_push_ff <= 1'b1;
						rx_st_ff <= RX_IDLE;
					end
				end
			end
			default: rx_st_ff <= RX_IDLE;
			endcase
		end
	end

	ubc_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH)) u_rxf (        // [R18]
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_clr(fcr_ff[FCR_RXRST]),
		.i_push(rx_push_ff && !rxf_full && (fifo_mode || rxf_empty)),
		.i_data(rx_ch_ff),
		.i_pop(rhr_rd),                              // [R19] [R22]
		.o_data(rxf_q),
		.o_empty(rxf_empty),
		.o_full(rxf_full),
		.o_count(rxf_cnt)
	);

	// Overrun sticky, cleared by status read; set wins
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			rx_ovr_ff <= 1'b0;
		else if (rx_push_ff && (rxf_full || (!fifo_mode && !rxf_empty)))
			rx_ovr_ff <= 1'b1;
		else if (lsr_rd)
			rx_ovr_ff <= 1'b0;
	end

	// ----------------------------------------
	// Receive timeout
	// ----------------------------------------
	logic [9:0] to_cnt_ff;
	logic [9:0] to_limit;
	logic to_ff, trig_hit;
	logic [4:0] trig_lvl;

	// Four word lengths (data bits only) plus twelve bits, in ticks
	assign to_limit = 10'({nbits, 2'b00} + 6'(TO_EXTRA_BITS)) << 4;
	always_comb begin
		case (fcr_ff[7:6])
		2'b00: trig_lvl = 5'd1;
		2'b01: trig_lvl = 5'd4;
		2'b10: trig_lvl = 5'd8;
		default: trig_lvl = 5'd14;
		endcase
	end
	assign trig_hit = fifo_mode ? rxf_cnt >= trig_lvl : !rxf_empty; // [R20]

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			to_cnt_ff <= 10'h000;
			to_ff <= 1'b0;
		end else if (rx_push_ff || rhr_rd || rxf_empty || !fifo_mode) begin
			to_cnt_ff <= 10'h000;                        // [R24]
			to_ff <= 1'b0;
		end else if (tick && !to_ff) begin
			to_cnt_ff <= to_cnt_ff + 10'h001;
			if (to_cnt_ff + 10'h001 == to_limit)
				to_ff <= 1'b1;                           // [R21]
		end
	end

	// ----------------------------------------
	// Interrupt and read path
	// ----------------------------------------
	logic [7:0] line_status_reg;
	logic [3:0] int_id;
	logic line_err, int_ff;
	logic txi_ff;

	assign line_err = !rxf_empty && (rxf_q.par || rxf_q.frm || rxf_q.brk);
	assign line_status_reg = {line_err, thr_empty_ff && tx_st_ff == TX_IDLE, // [R12]
		thr_empty_ff, rxf_q.brk & ~rxf_empty, rxf_q.frm & ~rxf_empty,
		rxf_q.par & ~rxf_empty, rx_ovr_ff, ~rxf_empty};         // [R17]

	// Transmit event cleared by interrupt ID read or new write
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			txi_ff <= 1'b0;
		else if (txf_empty && !thr_empty_ff)
			txi_ff <= 1'b1;
		else if (thr_wr || (i_acc.rd && i_acc.addr == ADDR_ISR_FCR &&
			int_id == ID_TXE))
			txi_ff <= 1'b0;
	end

	always_comb begin
		if (ier_ff[IER_LS] && (line_err || rx_ovr_ff))
			int_id = ID_LINE;
		else if (ier_ff[IER_RX] && to_ff)
			int_id = ID_TMO;                             // [R21]
		else if (ier_ff[IER_RX] && trig_hit)
			int_id = ID_RXD;                             // [R20]
		else if (ier_ff[IER_TX] && txi_ff)
			int_id = ID_TXE;                             // [R11]
		else
			int_id = ID_NONE;
	end

	always_comb begin
		case (i_acc.addr)
		ADDR_DATA: nxt_rdata = lcr_ff[LCR_DLAB] ? dll_ff : rxf_q.data;
		ADDR_IER: nxt_rdata = lcr_ff[LCR_DLAB] ? dlm_ff : ier_ff;
		ADDR_ISR_FCR: nxt_rdata = {{2{fifo_mode}}, 2'b00, int_id};
		ADDR_LCR: nxt_rdata = lcr_ff;
		ADDR_LSR: nxt_rdata = line_status_reg;
		ADDR_SPR: nxt_rdata = spr_ff;
		default: nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_ff <= 8'h00;
			int_ff <= 1'b0;
		end else begin
			if (i_acc.rd)
				rdata_ff <= nxt_rdata;
			int_ff <= int_id != ID_NONE;
		end
	end

	assign o_rdata = rdata_ff;
	// Break forces the line low regardless of shifter
	logic txo_ff;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			txo_ff <= 1'b1;
		else
			txo_ff <= tx_ff & ~lcr_ff[LCR_BRK];
	end
	assign o_tx = txo_ff;
	assign o_int = int_ff;
endmodule

// File: tb/ubc_core_sva.sv
module ubc_core_sva (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Host access
	input wire ubc_pkg::ubc_acc_t i_acc,
	input wire logic [7:0] o_rdata,
	// Line and interrupt
	input wire logic i_rx,
	input wire logic o_tx,
	input wire logic o_int
);
	import ubc_pkg::*;
	logic [7:0] lcr_ff;
	logic [15:0] div_ff;
	logic [2:0] ier_ff;
	int lowrun_ff;
	int bitc;

	// ----------------------------------------
	// Register shadows
	// ----------------------------------------
	// Zero divisor behaves as one
	assign bitc = (div_ff == 16'h0000) ? 256 : 256 * int'(div_ff);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lcr_ff <= LCR_RST;
			div_ff <= DIV_RST;
			ier_ff <= 3'h0;
		end else if (i_acc.wr) begin
			if (i_acc.addr == ADDR_LCR) begin
				lcr_ff <= i_acc.wdata;
			end
			if (i_acc.addr == ADDR_DATA && lcr_ff[LCR_DLAB]) begin
				div_ff[7:0] <= i_acc.wdata;
			end
			if (i_acc.addr == ADDR_IER && lcr_ff[LCR_DLAB]) begin
				div_ff[15:8] <= i_acc.wdata;
			end
			if (i_acc.addr == ADDR_IER && !lcr_ff[LCR_DLAB]) begin
				ier_ff <= i_acc.wdata[2:0];
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lowrun_ff <= 0;
		end else if (!o_tx) begin
			lowrun_ff <= lowrun_ff + 1;
		end else begin
			lowrun_ff <= 0;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	// Breaks held by the line control are not covered
	a_bit_len: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_tx) |-> (lowrun_ff % bitc) == 0)
		else $error("low run on tx not whole bits");
	a_start_min: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		$fell(o_tx) |=> !o_tx [*8])
		else $error("start bit too short");
	a_tx_idle: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> o_tx)
		else $error("tx not idle after reset");
	a_rdata_hold: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		!i_acc.rd |=> $stable(o_rdata))
		else $error("read data moved without read");
	a_int_masked: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		ier_ff == 3'h0 ##1 ier_ff == 3'h0 |-> !o_int)
		else $error("interrupt with all sources masked");
	a_div_low: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_acc.rd && i_acc.addr == ADDR_DATA && lcr_ff[LCR_DLAB]
		|=> o_rdata == div_ff[7:0])
		else $error("divisor low readback wrong");
	a_div_high: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_acc.rd && i_acc.addr == ADDR_IER && lcr_ff[LCR_DLAB]
		|=> o_rdata == div_ff[15:8])
		else $error("divisor high readback wrong");
	a_lcr_read: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_acc.rd && i_acc.addr == ADDR_LCR |=> o_rdata == lcr_ff)
		else $error("line control readback wrong");
endmodule

bind ubc_core ubc_core_sva ubc_core_sva_i (
	.i_clk(i_clk),
	.i_rst_n(i_rst_n),
	.i_acc(i_acc),
	.o_rdata(o_rdata),
	.i_rx(i_rx),
	.o_tx(o_tx),
	.o_int(o_int)
);

// File: tb/ubc_line_model.sv
module ubc_line_model (
	// Clock
	input wire logic i_clk,
	// Serial line
	input wire logic i_tx,
	output logic o_rx
);
	timeunit 1ns;
	timeprecision 100ps;
	int bit_clks = 256;
	bit par_on = 1'b0;
	int bad_cnt = 0;
	logic [7:0] rx_q[$];
	logic [7:0] sh;
	logic pb;

	// ----------------------------------------
	// Far-end receiver, centre sampling
	// ----------------------------------------
	initial begin
		o_rx = 1'b1;
		forever begin
			@(negedge i_tx);
			repeat (bit_clks / 2) @(posedge i_clk);
			if (i_tx === 1'b0) begin
				pb = 1'b0;
				for (int i = 0; i < 8; i++) begin
					repeat (bit_clks) @(posedge i_clk);
					sh[i] = i_tx;
					pb = pb ^ i_tx;
				end
				if (par_on) begin
					repeat (bit_clks) @(posedge i_clk);
					if (i_tx !== pb) bad_cnt++;
				end
				repeat (bit_clks) @(posedge i_clk);
				if (i_tx !== 1'b1) bad_cnt++;
				rx_q.push_back(sh);
			end
		end
	end

	// ----------------------------------------
	// Far-end transmitter
	// ----------------------------------------
	task automatic send(input logic [7:0] d, input logic stop_lvl);
		@(posedge i_clk);
		o_rx <= 1'b0;
		repeat (bit_clks) @(posedge i_clk);
		for (int i = 0; i < 8; i++) begin
			o_rx <= d[i];
			repeat (bit_clks) @(posedge i_clk);
		end
		o_rx <= stop_lvl;
		repeat (bit_clks) @(posedge i_clk);
		o_rx <= 1'b1;
		repeat (bit_clks) @(posedge i_clk);
	endtask

	// Short low pulse, must not start a character
	task automatic glitch(input int n);
		@(posedge i_clk);
		o_rx <= 1'b0;
		repeat (n) @(posedge i_clk);
		o_rx <= 1'b1;
		repeat (bit_clks * 2) @(posedge i_clk);
	endtask
endmodule

// File: tb/uart_baud_tx_rx_core_tb.sv
module uart_baud_tx_rx_core_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ubc_pkg::*;
	logic i_clk;
	logic i_rst_n;
	ubc_acc_t acc;
	logic [7:0] rdata;
	logic rx;
	logic tx;
	logic irq;
	logic [7:0] v;
	int err_total;
	int check_count;
	int cyc;

	ubc_core ubc_core_i (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_acc(acc),
		.o_rdata(rdata),
		.i_rx(rx),
		.o_tx(tx),
		.o_int(irq)
	);
	ubc_line_model ubc_line_model_i (
		.i_clk(i_clk),
		.i_tx(tx),
		.o_rx(rx)
	);

	// ----------------------------------------
	// Clock, watchdog and helpers
	// ----------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 95000) begin
			err_total++;
			final_report();
		end
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		acc <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk);
		acc <= '0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge i_clk);
		acc <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_clk);
		acc <= '0;
		@(posedge i_clk);
		#1;
		d = rdata;
	endtask

	task automatic wait_irq(input logic lvl, input int lim);
		for (int n = 0; n < lim && irq !== lvl; n++) @(posedge i_clk);
	endtask

	// Bit length follows divisor = clock / (256 * rate)
	task automatic set_div(input logic [15:0] dv, input logic [7:0] line_control_reg);
		wr(ADDR_LCR, 8'h80);
		wr(ADDR_DATA, dv[7:0]);
		wr(ADDR_IER, dv[15:8]);
		rd(ADDR_DATA, v);
		chk("divisor_low", dv[7:0], v);
		rd(ADDR_IER, v);
		chk("divisor_high", dv[15:8], v);
		wr(ADDR_LCR, line_control_reg);
		ubc_line_model_i.bit_clks = 256 * int'(dv);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd(ADDR_LCR, v);
		chk("lcr_reset", LCR_RST, v);
		rd(ADDR_LSR, v);
		chk("lsr_empty", 8'h60, v & 8'h60);
		wr(ADDR_LCR, 8'h80);
		rd(ADDR_DATA, v);
		chk("div_reset", DIV_RST[7:0], v);
		wr(ADDR_LCR, 8'h00);
	endtask

	task automatic t_tx_single;
		set_div(16'h0002, 8'h1B);
		ubc_line_model_i.par_on = 1'b1;
		wr(ADDR_DATA, 8'hA5);
		repeat (64) @(posedge i_clk);
		rd(ADDR_LSR, v);
		chk("thr_moved", 8'h20, v & 8'h60);
		wait (ubc_line_model_i.rx_q.size() > 0);
		chk("tx_byte", 8'hA5, ubc_line_model_i.rx_q.pop_front());
		chk("tx_frame", 8'h00, 8'(ubc_line_model_i.bad_cnt));
	endtask

	task automatic t_tx_fifo;
		set_div(16'h0001, 8'h03);
		ubc_line_model_i.par_on = 1'b0;
		wr(ADDR_ISR_FCR, 8'h01);
		wr(ADDR_IER, 8'h02);
		wait_irq(1'b1, 64);
		chk("txe_irq", 8'h01, {7'h00, irq});
		for (int i = 0; i < FIFO_DEPTH; i++) wr(ADDR_DATA, 8'(8'h30 + i));
		rd(ADDR_LSR, v);
		chk("fifo_busy", 8'h00, v & 8'h60);
		wait (ubc_line_model_i.rx_q.size() == FIFO_DEPTH);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			chk("fifo_byte", 8'(8'h30 + i), ubc_line_model_i.rx_q[i]);
		end
		ubc_line_model_i.rx_q.delete();
		repeat (256) @(posedge i_clk);
		chk("fifo_irq", 8'h01, {7'h00, irq});
		rd(ADDR_LSR, v);
		chk("all_empty", 8'h60, v & 8'h60);
		wr(ADDR_IER, 8'h00);
		repeat (4) @(posedge i_clk);
		chk("txe_masked", 8'h00, {7'h00, irq});
	endtask

	task automatic t_rx;
		wr(ADDR_IER, 8'h01);
		ubc_line_model_i.glitch(64);
		ubc_line_model_i.send(8'h3C, 1'b1);
		ubc_line_model_i.send(8'h5A, 1'b0);
		ubc_line_model_i.send(8'h81, 1'b1);
		chk("rx_irq", 8'h01, {7'h00, irq});
		rd(ADDR_LSR, v);
		chk("lsr_first", 8'h01, v & 8'h1D);
		rd(ADDR_DATA, v);
		chk("rx_oldest", 8'h3C, v);
		rd(ADDR_LSR, v);
		chk("lsr_frame", 8'h09, v & 8'h1D);
		rd(ADDR_DATA, v);
		chk("rx_second", 8'h5A, v);
		rd(ADDR_LSR, v);
		chk("lsr_clean", 8'h01, v & 8'h1D);
		rd(ADDR_DATA, v);
		chk("rx_third", 8'h81, v);
		repeat (4) @(posedge i_clk);
		chk("rx_irq_off", 8'h00, {7'h00, irq});
	endtask

	task automatic t_timeout;
		wr(ADDR_ISR_FCR, 8'hC1);
		ubc_line_model_i.send(8'h77, 1'b1);
		repeat (10600) @(posedge i_clk);
		chk("to_early", 8'h00, {7'h00, irq});
		wait_irq(1'b1, 1000);
		chk("to_irq", 8'h01, {7'h00, irq});
		rd(ADDR_ISR_FCR, v);
		chk("to_id", {4'hC, ID_TMO}, v);
		rd(ADDR_DATA, v);
		chk("to_data", 8'h77, v);
		repeat (4) @(posedge i_clk);
		chk("to_clear", 8'h00, {7'h00, irq});
	endtask

	// ----------------------------------------
	// Main sequence and verdict
	// ----------------------------------------
	task automatic final_report;
		if (err_total == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		err_total = 0;
		check_count = 0;
		cyc = 0;
		acc = '0;
		i_rst_n = 1'b0;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_tx_single();
		t_tx_fifo();
		t_rx();
		t_timeout();
		final_report();
	end
endmodule
